// file: verilog/btce_pkg.sv
// Package for the branch, trap and coprocessor execute block: opcode fields, encodings, ops.
// Assumes a classic 32-bit RISC encoding with the decode stage presenting one instruction.
// Contract
// - likely zero-compare branches test le, gt, lt, ge against zero.
// - likely link branches always write next-after-slot address to link_register; the code drops it when a move-from result is pending that cycle.
// - likely branches cancel the delay slot when not taken.
// - target is sign-extended offset shifted left two plus instruction address.
// - register equal trap fires when both sources match.
// - register not-equal trap fires when sources differ.
// - register ge trap, signed or unsigned compare.
// - register lt trap, signed or unsigned compare.
// - equal-immediate trap fires when source equals immediate.
// - not-equal-immediate trap fires when source differs from immediate.
// - ge-immediate traps, signed and unsigned.
// - lt-immediate traps, signed and unsigned.
// - system call always raises its exception at once.
// - breakpoint always raises its exception at once.
// - coprocessor load/store address is base plus sign-extended offset.
// - coprocessor load fetches memory word and hands it to the coprocessor.
// - data moves transfer a word between general and coprocessor data register.
// - control move-to copies general register into coprocessor control register.
// - control move-from writes coprocessor control register to general register.
package btce_pkg;
  localparam logic [5:0] OP_REGIMM = 6'h01;
  localparam logic [5:0] OP_SPECIAL = 6'h00;
  localparam logic [5:0] OP_BLE_L = 6'h16;
  localparam logic [5:0] OP_BGT_L = 6'h17;
  localparam logic [3:0] OP_COP_HI = 4'h4;
  localparam logic [3:0] OP_LWC_HI = 4'hC;
  localparam logic [3:0] OP_SWC_HI = 4'hE;
  localparam logic [4:0] RI_BLT_L = 5'h02;
  localparam logic [4:0] RI_BGE_L = 5'h03;
  localparam logic [4:0] RI_BLT_LINK_L = 5'h12;
  localparam logic [4:0] RI_BGE_LINK_L = 5'h13;
  localparam logic [4:0] RI_TGEI = 5'h08;
  localparam logic [4:0] RI_TRAP_IF_GE_IMM_UNSIGNED = 5'h09;
  localparam logic [4:0] RI_TRAP_IF_LT_IMM = 5'h0A;
  localparam logic [4:0] RI_TRAP_IF_LT_IMM_UNSIGNED = 5'h0B;
  localparam logic [4:0] RI_TRAP_IF_EQUAL_IMM = 5'h0C;
  localparam logic [4:0] RI_TRAP_IF_NOT_EQUAL_IMM = 5'h0E;
  localparam logic [5:0] FN_SYSTEM_CALL_TRAP = 6'h0C;
  localparam logic [5:0] FN_BREAK = 6'h0D;
  localparam logic [5:0] FN_TGE = 6'h30;
  localparam logic [5:0] FN_TRAP_IF_GE_UNSIGNED = 6'h31;
  localparam logic [5:0] FN_TLT = 6'h32;
  localparam logic [5:0] FN_TRAP_IF_LT_UNSIGNED = 6'h33;
  localparam logic [5:0] FN_TEQ = 6'h34;
  localparam logic [5:0] FN_TNE = 6'h36;
  localparam logic [4:0] CO_MF = 5'h00;
  localparam logic [4:0] CO_CF = 5'h02;
  localparam logic [4:0] CO_MT = 5'h04;
  localparam logic [4:0] CO_CT = 5'h06;
  localparam logic [4:0] LINK_REG = 5'h1F;
  localparam logic [31:0] SLOT_SKIP = 32'h0000_0008;
  // exception causes presented to the handler
  typedef enum logic [1:0] {
    BTCE_EXC_NONE = 2'b00,
    BTCE_EXC_TRAP = 2'b01,
    BTCE_EXC_SYSTEM_CALL_TRAP = 2'b10,
    BTCE_EXC_BREAK = 2'b11
  } btce_exc_e;
  // coprocessor transfer kinds
  typedef enum logic [2:0] {
    BTCE_CP_NONE = 3'b000,
    BTCE_CP_LOAD = 3'b001,
    BTCE_CP_STORE = 3'b010,
    BTCE_CP_MT = 3'b011,
    BTCE_CP_MF = 3'b100,
    BTCE_CP_CT = 3'b101,
    BTCE_CP_CF = 3'b110
  } btce_cp_e;
endpackage : btce_pkg

// file: verilog/btce_exec.sv
// Execute slice for likely branches, traps, system_call_trap/break and coprocessor transfers.
// Assumes the pipeline presents one valid instruction with operands; results register once.
`timescale 1ns/10ps
module btce_exec
  import btce_pkg::*;
(
  // clock and reset
  input wire logic mclk_in,
  input wire logic nrst_in,
  // instruction from issue
  input wire logic valid_in,
  input wire logic [31:0] instr_in,
  input wire logic [31:0] pc_in,
  input wire logic [31:0] first_source_reg_in,
  input wire logic [31:0] second_source_reg_in,
  // answers from coprocessor and memory, same clock
  input wire logic [31:0] cop_rdata_in,
  input wire logic [31:0] mem_rdata_in,
  // branch outcome
  output logic branch_taken_out,
  output logic [31:0] branch_target_out,
  output logic cancel_slot_out,
  // general register write-back
  output logic gpr_we_out,
  output logic [4:0] gpr_addr_out,
  output logic [31:0] gpr_data_out,
  // exception request
  output logic exc_req_out,
  output logic [1:0] exc_cause_out,
  // memory access for coprocessor load/store
  output logic mem_rd_out,
  output logic mem_wr_out,
  output logic [31:0] mem_addr_out,
  output logic [31:0] mem_wdata_out,
  // coprocessor side
  output logic [1:0] cop_unit_out,
  output logic [4:0] cop_reg_out,
  output logic cop_wr_out,
  output logic cop_ctrl_out,
  output logic cop_rd_out,
  output logic [31:0] cop_wdata_out
);

  // sign-extend a 16-bit field, shared by targets, traps and addresses
  function automatic logic [31:0] btce_sext(input logic [15:0] v);
    btce_sext = {{16{v[15]}}, v};
  endfunction : btce_sext

  logic [5:0] opc;
  logic [4:0] rt_f;
  logic [4:0] rd_f;
  logic [5:0] fn;
  logic [31:0] imm_x;
  logic [31:0] a;
  logic [31:0] b;
  logic [31:0] next_target;
  logic [31:0] ea;
  logic is_br;
  logic is_link;
  logic cond;
  logic trap_hit;
  btce_exc_e next_exc;
  btce_cp_e cp_kind;
  logic ld_pend;
  logic [4:0] ld_reg;
  logic [1:0] ld_unit;
  logic mf_pend;
  logic [4:0] mf_reg;

  // field split and shared arithmetic
  assign opc = instr_in[31:26];
  assign rt_f = instr_in[20:16];
  assign rd_f = instr_in[15:11];
  assign fn = instr_in[5:0];
  assign a = first_source_reg_in;
  assign b = second_source_reg_in;
  assign imm_x = btce_sext(instr_in[15:0]);
  assign next_target = pc_in + {imm_x[29:0], 2'b00};
  assign ea = a + imm_x;

  // decode: branch condition, trap condition, exception cause, coprocessor kind
  always_comb
  begin
    is_br = 1'b0;
    is_link = 1'b0;
    cond = 1'b0;
    trap_hit = 1'b0;
    next_exc = BTCE_EXC_NONE;
    cp_kind = BTCE_CP_NONE;
    if (opc == OP_BLE_L)
    begin
      is_br = 1'b1;
      cond = $signed(a) <= 0;
    end
    else if (opc == OP_BGT_L)
    begin
      is_br = 1'b1;
      cond = $signed(a) > 0;
    end
    else if (opc == OP_REGIMM)
    begin
      case (rt_f)
        RI_BLT_L: begin is_br = 1'b1; cond = a[31]; end
        RI_BGE_L: begin is_br = 1'b1; cond = !a[31]; end
        RI_BLT_LINK_L: begin is_br = 1'b1; is_link = 1'b1; cond = a[31]; end
        RI_BGE_LINK_L: begin is_br = 1'b1; is_link = 1'b1; cond = !a[31]; end
        RI_TRAP_IF_EQUAL_IMM: trap_hit = a == imm_x;
        RI_TRAP_IF_NOT_EQUAL_IMM: trap_hit = a != imm_x;
        RI_TGEI: trap_hit = $signed(a) >= $signed(imm_x);
        RI_TRAP_IF_GE_IMM_UNSIGNED: trap_hit = a >= imm_x;
        RI_TRAP_IF_LT_IMM: trap_hit = $signed(a) < $signed(imm_x);
        RI_TRAP_IF_LT_IMM_UNSIGNED: trap_hit = a < imm_x;
        default: trap_hit = 1'b0;
      endcase
    end
    else if (opc == OP_SPECIAL)
    begin
      case (fn)
        FN_TEQ: trap_hit = a == b;
        FN_TNE: trap_hit = a != b;
        FN_TGE: trap_hit = $signed(a) >= $signed(b);
        FN_TRAP_IF_GE_UNSIGNED: trap_hit = a >= b;
        FN_TLT: trap_hit = $signed(a) < $signed(b);
        FN_TRAP_IF_LT_UNSIGNED: trap_hit = a < b;
        FN_SYSTEM_CALL_TRAP: next_exc = BTCE_EXC_SYSTEM_CALL_TRAP;
        FN_BREAK: next_exc = BTCE_EXC_BREAK;
        default: next_exc = BTCE_EXC_NONE;
      endcase
    end
    else if (opc[5:2] == OP_LWC_HI)
    begin
      cp_kind = BTCE_CP_LOAD;
    end
    else if (opc[5:2] == OP_SWC_HI)
    begin
      cp_kind = BTCE_CP_STORE;
    end
    else if (opc[5:2] == OP_COP_HI)
    begin
      case (instr_in[25:21])
        CO_MF: cp_kind = BTCE_CP_MF;
        CO_MT: cp_kind = BTCE_CP_MT;
        CO_CF: cp_kind = BTCE_CP_CF;
        CO_CT: cp_kind = BTCE_CP_CT;
        default: cp_kind = BTCE_CP_NONE;
      endcase
    end
    if (trap_hit)
    begin
      next_exc = BTCE_EXC_TRAP;
    end
  end

  // branch outcome and exception request, registered
  always_ff @(posedge mclk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      branch_taken_out <= 1'b0;
      branch_target_out <= 32'h0000_0000;
      cancel_slot_out <= 1'b0;
      exc_req_out <= 1'b0;
      exc_cause_out <= 2'h0;
    end
    else
    begin
      branch_taken_out <= valid_in && is_br && cond;
      branch_target_out <= next_target;
      cancel_slot_out <= valid_in && is_br && !cond;
      exc_req_out <= valid_in && (next_exc != BTCE_EXC_NONE);
      exc_cause_out <= valid_in ? next_exc : BTCE_EXC_NONE;
    end
  end

  // pending answers: load data and move-from results arrive one cycle after issue, in the same cycle as the registered request
  always_ff @(posedge mclk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      ld_pend <= 1'b0;
      ld_reg <= 5'h00;
      ld_unit <= 2'h0;
      mf_pend <= 1'b0;
      mf_reg <= 5'h00;
    end
    else
    begin
      ld_pend <= valid_in && cp_kind == BTCE_CP_LOAD;
      ld_reg <= rt_f;
      ld_unit <= opc[1:0];
      mf_pend <= valid_in && (cp_kind == BTCE_CP_MF || cp_kind == BTCE_CP_CF);
      mf_reg <= rt_f;
    end
  end

  // memory request and coprocessor write/read, registered
  always_ff @(posedge mclk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      mem_rd_out <= 1'b0;
      mem_wr_out <= 1'b0;
      mem_addr_out <= 32'h0000_0000;
      mem_wdata_out <= 32'h0000_0000;
      cop_unit_out <= 2'h0;
      cop_reg_out <= 5'h00;
      cop_wr_out <= 1'b0;
      cop_ctrl_out <= 1'b0;
      cop_rd_out <= 1'b0;
      cop_wdata_out <= 32'h0000_0000;
    end
    else
    begin
      mem_rd_out <= valid_in && cp_kind == BTCE_CP_LOAD;
      mem_wr_out <= valid_in && cp_kind == BTCE_CP_STORE;
      mem_addr_out <= ea;
      mem_wdata_out <= cop_rdata_in;
      if (ld_pend)
      begin
        // load data from memory goes straight to the coprocessor register
        cop_unit_out <= ld_unit;
        cop_reg_out <= ld_reg;
        cop_wr_out <= 1'b1;
        cop_ctrl_out <= 1'b0;
        cop_rd_out <= 1'b0;
        cop_wdata_out <= mem_rdata_in;
      end
      else
      begin
        cop_unit_out <= opc[1:0];
        cop_reg_out <= (cp_kind == BTCE_CP_STORE) ? rt_f : rd_f;
        cop_wr_out <= valid_in && (cp_kind == BTCE_CP_MT || cp_kind == BTCE_CP_CT);
        cop_ctrl_out <= cp_kind == BTCE_CP_CT || cp_kind == BTCE_CP_CF;
        cop_rd_out <= valid_in && (cp_kind == BTCE_CP_MF || cp_kind == BTCE_CP_CF
          || cp_kind == BTCE_CP_STORE);
        cop_wdata_out <= b;
      end
    end
  end

  // general register write-back: link address or coprocessor move-from result
  always_ff @(posedge mclk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      gpr_we_out <= 1'b0;
      gpr_addr_out <= 5'h00;
      gpr_data_out <= 32'h0000_0000;
    end
    else if (mf_pend)
    begin
      gpr_we_out <= 1'b1;
      gpr_addr_out <= mf_reg;
      gpr_data_out <= cop_rdata_in;
    end
    else
    begin
      // link written whether or not the branch is taken
      gpr_we_out <= valid_in && is_link;
      gpr_addr_out <= LINK_REG;
      gpr_data_out <= pc_in + SLOT_SKIP;
    end
  end

  // link write never waits on the branch condition
  link_always_a: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    valid_in && is_link && !mf_pend |=> gpr_we_out && gpr_addr_out == LINK_REG
    && gpr_data_out == $past(pc_in) + SLOT_SKIP)
    else $error("link register not written");
  // taken and cancelled exclude each other and follow condition
  slot_cancel_a: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    valid_in && is_br |=> (branch_taken_out != cancel_slot_out)
    && branch_taken_out == $past(cond))
    else $error("delay slot handling wrong");
  target_calc_a: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    branch_taken_out |-> branch_target_out ==
    $past(pc_in) + {{14{$past(instr_in[15])}}, $past(instr_in[15:0]), 2'b00})
    else $error("branch target wrong");
  teq_reg_a: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    valid_in && opc == OP_SPECIAL && fn == FN_TEQ |=> exc_req_out == $past(a == b))
    else $error("equal trap wrong");
  tne_reg_a: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    valid_in && opc == OP_SPECIAL && fn == FN_TNE |=> exc_req_out == $past(a != b))
    else $error("not-equal trap wrong");
  trap_if_ge_unsigned_reg_a: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    valid_in && opc == OP_SPECIAL && fn == FN_TRAP_IF_GE_UNSIGNED |=> exc_req_out == $past(a >= b))
    else $error("unsigned ge trap wrong");
  tlt_reg_a: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    valid_in && opc == OP_SPECIAL && fn == FN_TLT
    |=> exc_req_out == $past($signed(a) < $signed(b)))
    else $error("signed lt trap wrong");
  trap_if_lt_imm_unsigned_imm_a: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    valid_in && opc == OP_REGIMM && rt_f == RI_TRAP_IF_LT_IMM_UNSIGNED
    |=> exc_req_out == $past(a < {{16{instr_in[15]}}, instr_in[15:0]}))
    else $error("unsigned lt imm trap wrong");
  system_call_trap_now_a: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    valid_in && opc == OP_SPECIAL && fn == FN_SYSTEM_CALL_TRAP
    |=> exc_req_out && exc_cause_out == BTCE_EXC_SYSTEM_CALL_TRAP)
    else $error("system_call_trap not raised");
  load_deliver_a: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    valid_in && cp_kind == BTCE_CP_LOAD |=> mem_rd_out ##1 cop_wr_out
    && cop_wdata_out == $past(mem_rdata_in))
    else $error("coprocessor load not delivered");
endmodule : btce_exec

// file: verification/btce_cop_mem_model.sv
// coprocessor register files and a scrambled memory facing the execute slice
// assumes the slice clock and reset; all units share one register set
`timescale 1ns/10ps
module btce_cop_mem_model
  import btce_pkg::*;
(
  // clock and reset
  input wire logic mclk_in,
  input wire logic nrst_in,
  // issue view and slice requests
  input wire logic valid_in,
  input wire logic [31:0] instr_in,
  input wire logic mem_rd_in,
  input wire logic [31:0] mem_addr_in,
  input wire logic cop_rd_in,
  input wire logic cop_wr_in,
  input wire logic cop_ctrl_in,
  input wire logic [4:0] cop_reg_in,
  input wire logic [31:0] cop_wdata_in,
  // answers
  output logic [31:0] cop_rdata_out,
  output logic [31:0] mem_rdata_out
);
  logic [31:0] dreg [32];
  logic [31:0] creg [32];
  logic rd_q;
  logic [31:0] addr_q;
  logic [31:0] noise;
  // latch writes; noise keeps idle answer lines moving so stale data never matches
  always_ff @(posedge mclk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      dreg <= '{default: '0};
      creg <= '{default: '0};
      rd_q <= 1'b0;
      addr_q <= '0;
      noise <= 32'h1357_9BDF;
    end
    else
    begin
      if (cop_wr_in && cop_ctrl_in) creg[cop_reg_in] <= cop_wdata_in;
      if (cop_wr_in && !cop_ctrl_in) dreg[cop_reg_in] <= cop_wdata_in;
      rd_q <= mem_rd_in;
      addr_q <= mem_addr_in;
      noise <= {noise[30:0], noise[31]} ^ 32'h0000_00A5;
    end
  end
  // read data is shown at once, memory data held one more cycle, covering either sampling point
  always_comb
  begin
    mem_rdata_out = ~noise;
    if (mem_rd_in) mem_rdata_out = mem_addr_in ^ 32'hA5C3_0F96;
    else if (rd_q) mem_rdata_out = addr_q ^ 32'hA5C3_0F96;
    cop_rdata_out = noise;
    if (cop_rd_in)
      cop_rdata_out = cop_ctrl_in ? creg[cop_reg_in] : dreg[cop_reg_in];
    else if (valid_in && instr_in[31:28] == OP_SWC_HI)
      cop_rdata_out = dreg[instr_in[20:16]];
  end
endmodule : btce_cop_mem_model

// file: verification/btce_exec_tb.sv
// self-checking bench for the execute slice with random operands and corner pairs
// assumes the coprocessor and memory model answers as the slice expects
`timescale 1ns/10ps
module btce_exec_tb
  import btce_pkg::*;
();
  logic mclk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic valid = 1'b0;
  logic [31:0] instr = '0;
  logic [31:0] pc = '0;
  logic [31:0] a = '0;
  logic [31:0] b = '0;
  logic [31:0] cop_rdata, mem_rdata, branch_target_out, gpr_data_out, mem_addr_out;
  logic [31:0] mem_wdata_out, cop_wdata_out;
  logic branch_taken_out, cancel_slot_out, gpr_we_out, exc_req_out, mem_rd_out, mem_wr_out;
  logic cop_wr_out, cop_ctrl_out, cop_rd_out;
  logic [4:0] gpr_addr_out, cop_reg_out;
  logic [1:0] exc_cause_out, cop_unit_out;
  logic [31:0] seed = 32'h0000_0040;
  logic [31:0] sd [32];
  logic [31:0] sc [32];
  int bad_count = 0;
  int check_count = 0;
  int cycles = 0;
  logic [31:0] cx [6] = '{32'h0, 32'hFFFF_8000, 32'h0000_7FFF, 32'h8000_0000, 32'h7FFF_FFFF, 32'h1};
  logic [31:0] cy [6] = '{32'h0, 32'hFFFF_8000, 32'hFFFF_8000, 32'h1, 32'h0, 32'h1234_0001};

  always #20 mclk_in = ~mclk_in;

  btce_exec i_dut (.mclk_in(mclk_in), .nrst_in(nrst_in), .valid_in(valid), .instr_in(instr),
    .pc_in(pc), .first_source_reg_in(a), .second_source_reg_in(b), .cop_rdata_in(cop_rdata),
    .mem_rdata_in(mem_rdata), .branch_taken_out(branch_taken_out),
    .branch_target_out(branch_target_out), .cancel_slot_out(cancel_slot_out),
    .gpr_we_out(gpr_we_out), .gpr_addr_out(gpr_addr_out), .gpr_data_out(gpr_data_out),
    .exc_req_out(exc_req_out), .exc_cause_out(exc_cause_out), .mem_rd_out(mem_rd_out),
    .mem_wr_out(mem_wr_out), .mem_addr_out(mem_addr_out), .mem_wdata_out(mem_wdata_out),
    .cop_unit_out(cop_unit_out), .cop_reg_out(cop_reg_out), .cop_wr_out(cop_wr_out),
    .cop_ctrl_out(cop_ctrl_out), .cop_rd_out(cop_rd_out), .cop_wdata_out(cop_wdata_out));

  btce_cop_mem_model i_model (.mclk_in(mclk_in), .nrst_in(nrst_in), .valid_in(valid),
    .instr_in(instr), .mem_rd_in(mem_rd_out), .mem_addr_in(mem_addr_out),
    .cop_rd_in(cop_rd_out), .cop_wr_in(cop_wr_out), .cop_ctrl_in(cop_ctrl_out),
    .cop_reg_in(cop_reg_out), .cop_wdata_in(cop_wdata_out), .cop_rdata_out(cop_rdata),
    .mem_rdata_out(mem_rdata));

  // lfsr source of every random value
  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction : rnd

  // encodings of the twenty branch, trap and exception cases
  function automatic logic [31:0] enc(input int k, input logic [15:0] im);
    case (k)
      0: return {OP_BLE_L, 5'h3, 5'h0, im};
      1: return {OP_BGT_L, 5'h3, 5'h0, im};
      2: return {OP_REGIMM, 5'h3, RI_BLT_L, im};
      3: return {OP_REGIMM, 5'h3, RI_BGE_L, im};
      4: return {OP_REGIMM, 5'h3, RI_BLT_LINK_L, im};
      5: return {OP_REGIMM, 5'h3, RI_BGE_LINK_L, im};
      6: return {OP_SPECIAL, 10'h064, 10'h0, FN_TEQ};
      7: return {OP_SPECIAL, 10'h064, 10'h0, FN_TNE};
      8: return {OP_SPECIAL, 10'h064, 10'h0, FN_TGE};
      9: return {OP_SPECIAL, 10'h064, 10'h0, FN_TRAP_IF_GE_UNSIGNED};
      10: return {OP_SPECIAL, 10'h064, 10'h0, FN_TLT};
      11: return {OP_SPECIAL, 10'h064, 10'h0, FN_TRAP_IF_LT_UNSIGNED};
      12: return {OP_REGIMM, 5'h3, RI_TRAP_IF_EQUAL_IMM, im};
      13: return {OP_REGIMM, 5'h3, RI_TRAP_IF_NOT_EQUAL_IMM, im};
      14: return {OP_REGIMM, 5'h3, RI_TGEI, im};
      15: return {OP_REGIMM, 5'h3, RI_TRAP_IF_GE_IMM_UNSIGNED, im};
      16: return {OP_REGIMM, 5'h3, RI_TRAP_IF_LT_IMM, im};
      17: return {OP_REGIMM, 5'h3, RI_TRAP_IF_LT_IMM_UNSIGNED, im};
      18: return {OP_SPECIAL, 20'h0, FN_SYSTEM_CALL_TRAP};
      default: return {OP_SPECIAL, 20'h0, FN_BREAK};
    endcase
  endfunction : enc

  // expected condition; immediate forms compare with the sign-extended field
  function automatic logic cond(input int k, input logic [31:0] x, input logic [31:0] y);
    logic [31:0] r;
    r = (k >= 12) ? {{16{y[15]}}, y[15:0]} : y;
    case (k)
      0: return $signed(x) <= 0;
      1: return $signed(x) > 0;
      2, 4: return x[31];
      3, 5: return !x[31];
      6, 12: return x == r;
      7, 13: return x != r;
      8, 14: return $signed(x) >= $signed(r);
      9, 15: return x >= r;
      10, 16: return $signed(x) < $signed(r);
      11, 17: return x < r;
      default: return 1'b1;
    endcase
  endfunction : cond

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // one valid cycle, then idle with random ignored instruction bits
  task automatic issue(input logic [31:0] ins, input logic [31:0] p, input logic [31:0] x,
    input logic [31:0] y);
    @(negedge mclk_in);
    valid = 1'b1;
    instr = ins;
    pc = p;
    a = x;
    b = y;
    @(negedge mclk_in);
    valid = 1'b0;
    instr = rnd();
  endtask : issue

  task automatic run_op(input int k, input logic [31:0] x, input logic [31:0] y);
    logic [31:0] p;
    logic t;
    p = rnd() & 32'hFFFF_FFFC;
    t = cond(k, x, y);
    issue(enc(k, y[15:0]), p, x, y);
    chk(32'(branch_taken_out), 32'(k < 6 && t));
    chk(32'(cancel_slot_out), 32'(k < 6 && !t));
    if (k < 6 && t) chk(branch_target_out, p + {{14{y[15]}}, y[15:0], 2'b00});
    chk(32'(gpr_we_out), 32'(k == 4 || k == 5));
    if (k == 4 || k == 5) chk({27'h0, gpr_addr_out} ^ gpr_data_out, 32'h1F ^ (p + 32'h8));
    chk(32'(exc_req_out), 32'(k >= 6 && t));
    if (k >= 6 && t) chk(32'(exc_cause_out), (k < 18) ? 32'h1 : 32'(k - 16));
    chk(32'({mem_rd_out, mem_wr_out, cop_wr_out, cop_rd_out}), 32'h0);
  endtask : run_op

  // c: 0 data to, 1 control to, 2 data from, 3 control from, 4 load, 5 store
  task automatic cop_op(input int c);
    logic [31:0] w, x, y, ea;
    logic [4:0] co;
    w = rnd();
    x = rnd();
    y = rnd();
    ea = x + {{16{w[31]}}, w[31:16]};
    co = (c == 0) ? CO_MT : (c == 1) ? CO_CT : (c == 2) ? CO_MF : CO_CF;
    if (c < 4) issue({OP_COP_HI, w[1:0], co, 5'h4, w[9:5], 11'h0}, 32'h0, x, y);
    else issue({(c == 4) ? OP_LWC_HI : OP_SWC_HI, w[1:0], 5'h3, 2'b00, w[4:2], w[31:16]}, 0, x, y);
    // moves-to write, moves-from read, a load reads memory, a store reads the unit and writes memory
    chk(32'({cop_wr_out, cop_rd_out, mem_rd_out, mem_wr_out}),
      (c < 2) ? 32'h8 : (c < 4) ? 32'h4 : (c == 4) ? 32'h2 : 32'h5);
    if (c < 4) chk({cop_unit_out, cop_reg_out, cop_ctrl_out}, {w[1:0], w[9:5], c[0]});
    if (c < 2) chk(cop_wdata_out, y);
    if (c > 3) chk(mem_addr_out, ea);
    if (c == 5) chk(mem_wdata_out, sd[w[4:2]]);
    if (c == 0) sd[w[9:5]] = y;
    if (c == 1) sc[w[9:5]] = y;
    @(negedge mclk_in);
    chk(32'({gpr_we_out, cop_wr_out}), (c == 2 || c == 3) ? 32'h2 : 32'(c == 4));
    if (c == 2 || c == 3) chk(gpr_data_out, (c == 3) ? sc[w[9:5]] : sd[w[9:5]]);
    if (c == 2 || c == 3) chk(32'(gpr_addr_out), 32'h4);
    if (c == 4) chk({cop_unit_out, cop_reg_out}, {w[1:0], 2'b00, w[4:2]});
    if (c == 4) chk(cop_wdata_out, ea ^ 32'hA5C3_0F96);
    if (c == 4) sd[w[4:2]] = ea ^ 32'hA5C3_0F96;
  endtask : cop_op

  task automatic finish_test();
    $display("checks %0d, mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : finish_test

  // hang guard, well above the roughly 2300 cycles of the full run
  always @(posedge mclk_in)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      bad_count++;
      finish_test();
    end
  end

  // reset, corner operand pairs first, then random ones
  initial
  begin
    logic [31:0] x, y;
    sd = '{default: '0};
    sc = '{default: '0};
    repeat (4) @(negedge mclk_in);
    chk(32'({branch_taken_out, cancel_slot_out, gpr_we_out, exc_req_out, cop_wr_out}), 32'h0);
    nrst_in = 1'b1;
    for (int it = 0; it < 40; it++)
    begin
      x = (it < 6) ? cx[it] : rnd();
      y = (it < 6) ? cy[it] : rnd();
      for (int k = 0; k < 20; k++) run_op(k, x, y);
      for (int c = 0; c < 6; c++) cop_op(c);
    end
    finish_test();
  end
endmodule : btce_exec_tb
